// [core/gpp_pkg.sv]
// Package: register map, reset values and pin layout of the general purpose port block
package gpp_pkg;
	localparam int GPP_WIDTH = 8;
	localparam logic [7:0] GPP_ADDR_P0_DATA = 8'h00;
	localparam logic [7:0] GPP_ADDR_P0_DIR = 8'h04;
	localparam logic [7:0] GPP_ADDR_P0_PULL = 8'h08;
	localparam logic [7:0] GPP_ADDR_P1_DATA = 8'h0C;
	localparam logic [7:0] GPP_ADDR_P1_DIR = 8'h10;
	localparam logic [7:0] GPP_ADDR_P1_PULL = 8'h14;
	localparam logic [7:0] GPP_ADDR_AIN_DIS = 8'h18;
	localparam logic [7:0] GPP_ADDR_CTRL = 8'h1C;
	localparam logic [7:0] GPP_ADDR_P0_RMW = 8'h20;
	localparam logic [7:0] GPP_ADDR_P1_RMW = 8'h24;
	localparam logic [7:0] GPP_RST_BYTE = 8'h00;
	localparam int GPP_CTRL_PIN_HOLD_BIT = 0;
	localparam int GPP_CTRL_CMP_DIS_BIT = 1;
	localparam logic [7:0] GPP_P0_ANALOG_MASK = 8'hF0;
	localparam logic [7:0] GPP_P1_OPEN_DRAIN_MASK = 8'h00;
	localparam logic [7:0] GPP_P1_PULL_MASK = 8'hFE;
	localparam logic [7:0] GPP_P0_OPEN_DRAIN_MASK = 8'h00;
	localparam logic [7:0] GPP_P0_PULL_MASK = 8'hFF;
	localparam logic [2:0] GPP_HSIZE_WORD = 3'h2;
	localparam logic [1:0] GPP_HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {GPP_BUS_IDLE, GPP_BUS_DATA} gpp_bus_state_e;
	// Maps analog disable register bits onto port 0 pins 4..7
	function automatic logic [7:0] gpp_ain_to_pins(input logic [7:0] ain);
		gpp_ain_to_pins = {ain[5], ain[4], ain[1], ain[0], 4'h0};
	endfunction
endpackage

// [core/gpp_pin_ctrl.sv]
// One 8-bit port: pin drive, pull-up, standby gating and input paths
module gpp_pin_ctrl import gpp_pkg::*; #(
	parameter logic [7:0] OPEN_DRAIN_MASK = 8'h00,
	parameter logic [7:0] PULL_MASK = 8'hFF
) (
	input wire logic [7:0] latch_in,
	input wire logic [7:0] dir_in,
	input wire logic [7:0] pull_in,
	input wire logic [7:0] periph_oe_in,
	input wire logic [7:0] periph_out_in,
	input wire logic [7:0] digital_en_in,
	input wire logic [7:0] wake_en_in,
	input wire logic standby_hold_in,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_out,
	output logic [7:0] pullup_out,
	output logic [7:0] pin_level_out,
	output logic [7:0] irq_level_out
);
	logic [7:0] drive_val;
	logic [7:0] drive_en;
	logic [7:0] path_open;
	// Peripheral output takes precedence over the port latch
	always_comb begin
		for (int i = 0; i < GPP_WIDTH; i++) begin
			drive_val[i] = periph_oe_in[i] ? periph_out_in[i] : latch_in[i];
			drive_en[i] = periph_oe_in[i] | dir_in[i];
			// Open drain cannot drive high, it releases the pin
			if (OPEN_DRAIN_MASK[i] && drive_val[i]) begin
				drive_en[i] = 1'b0;
			end
		end
	end
	// Standby hold floats every pin; hold select low keeps drive as is
	assign pin_oe_out = standby_hold_in ? 8'h00 : drive_en;
	assign pin_out = drive_val;
	// Pull-up dropped while the pin drives low, and on pins without one
	assign pullup_out = pull_in & PULL_MASK & ~(pin_oe_out & ~drive_val);
	// Blocked inputs read low to avoid leakage from a floating pin
	assign path_open = standby_hold_in ? wake_en_in : 8'hFF;
	assign pin_level_out = pin_in & digital_en_in & path_open;
	assign irq_level_out = pin_in & path_open;
endmodule // gpp_pin_ctrl

// [core/gpp_ahb_slave.sv]
// AHB-Lite single-word slave front end with zero wait states
module gpp_ahb_slave import gpp_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic wr_en_out,
	output logic [7:0] wr_addr_out,
	output logic rd_en_out,
	output logic [7:0] rd_addr_out
);
	gpp_bus_state_e state_reg;
	logic [7:0] addr_reg;
	logic wr_reg;
	logic take;
	assign take = hsel_in & hready_in & (htrans_in == GPP_HTRANS_NONSEQ)
		& (hsize_in == GPP_HSIZE_WORD);
	// Address phase capture; data phase lasts one cycle
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_reg <= GPP_BUS_IDLE;
			addr_reg <= 8'h00;
			wr_reg <= 1'b0;
		end else begin
			state_reg <= take ? GPP_BUS_DATA : GPP_BUS_IDLE;
			if (take) begin
				addr_reg <= haddr_in[7:0];
				wr_reg <= hwrite_in;
			end
		end
	end
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	// Reads decode in the address phase so data is registered for the data phase
	assign rd_en_out = take & ~hwrite_in;
	assign rd_addr_out = haddr_in[7:0];
	assign wr_en_out = (state_reg == GPP_BUS_DATA) & wr_reg;
	assign wr_addr_out = addr_reg;
endmodule // gpp_ahb_slave

// [core/gpp_port_top.sv]
// Top of the two-port general purpose I/O block with its register file
//
// The register offsets and the AHB-Lite register port were left to the implementer.
module gpp_port_top import gpp_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic standby_entry_in,
	input wire logic [7:0] p0_periph_oe_in,
	input wire logic [7:0] p0_periph_out_in,
	input wire logic [7:0] p1_periph_oe_in,
	input wire logic [7:0] p1_periph_out_in,
	input wire logic [7:0] p0_irq_enable_in,
	input wire logic [7:0] p1_wake_enable_in,
	input wire logic [7:0] p0_pin_in,
	input wire logic [7:0] p1_pin_in,
	output logic [7:0] p0_pin_out,
	output logic [7:0] p0_pin_oe_out,
	output logic [7:0] p0_pullup_out,
	output logic [7:0] p1_pin_out,
	output logic [7:0] p1_pin_oe_out,
	output logic [7:0] p1_pullup_out,
	output logic [7:0] p0_irq_level_out,
	output logic [7:0] p1_irq_level_out,
	output logic [7:0] p0_analog_en_out,
	output logic comparator_input_en_out
);
	logic [7:0] port0_data_latch_reg;
	logic [7:0] port0_direction_reg;
	logic [7:0] port0_pullup_enable_reg;
	logic [7:0] port1_data_latch_reg;
	logic [7:0] port1_direction_reg;
	logic [7:0] port1_pullup_enable_reg;
	logic [7:0] analog_input_disable_low_reg;
	logic [7:0] ctrl_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wr_en;
	logic rd_en;
	logic [7:0] wr_addr;
	logic [7:0] rd_addr;
	logic [7:0] p0_level;
	logic [7:0] p1_level;
	logic [7:0] p0_dig_en;
	logic hold;
	// Bus front end
	gpp_ahb_slave u_bus (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(hsize_in),
		.hready_in(hready_in),
		.hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.rd_en_out(rd_en),
		.rd_addr_out(rd_addr)
	);
	// Data latches take every write, whatever the direction
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			port0_data_latch_reg <= GPP_RST_BYTE;
			port1_data_latch_reg <= GPP_RST_BYTE;
		end else if (wr_en) begin
			if (wr_addr == GPP_ADDR_P0_DATA || wr_addr == GPP_ADDR_P0_RMW) begin
				port0_data_latch_reg <= hwdata_in[7:0];
			end
			if (wr_addr == GPP_ADDR_P1_DATA || wr_addr == GPP_ADDR_P1_RMW) begin
				port1_data_latch_reg <= hwdata_in[7:0];
			end
		end
	end
	// Direction registers clear on reset so all pins come up as inputs
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			port0_direction_reg <= GPP_RST_BYTE;
			port1_direction_reg <= GPP_RST_BYTE;
		end else if (wr_en) begin
			if (wr_addr == GPP_ADDR_P0_DIR) begin
				port0_direction_reg <= hwdata_in[7:0];
			end
			if (wr_addr == GPP_ADDR_P1_DIR) begin
				port1_direction_reg <= hwdata_in[7:0];
			end
		end
	end
	// Pull-up registers; second port bit 0 is kept even though unused
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			port0_pullup_enable_reg <= GPP_RST_BYTE;
			port1_pullup_enable_reg <= GPP_RST_BYTE;
		end else if (wr_en) begin
			if (wr_addr == GPP_ADDR_P0_PULL) begin
				port0_pullup_enable_reg <= hwdata_in[7:0];
			end
			if (wr_addr == GPP_ADDR_P1_PULL) begin
				port1_pullup_enable_reg <= hwdata_in[7:0];
			end
		end
	end
	// Analog disable and control; reset leaves analog pins digitally blocked
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			analog_input_disable_low_reg <= GPP_RST_BYTE;
			ctrl_reg <= GPP_RST_BYTE;
		end else if (wr_en) begin
			if (wr_addr == GPP_ADDR_AIN_DIS) begin
				analog_input_disable_low_reg <= hwdata_in[7:0];
			end
			if (wr_addr == GPP_ADDR_CTRL) begin
				ctrl_reg <= hwdata_in[7:0];
			end
		end
	end
	// Pin hold applies only in stop or watch with hold select set
	assign hold = standby_entry_in & ctrl_reg[GPP_CTRL_PIN_HOLD_BIT];
	// Pins without an analog function always have digital input
	assign p0_dig_en = ~GPP_P0_ANALOG_MASK | gpp_ain_to_pins(analog_input_disable_low_reg);
	assign p0_analog_en_out = GPP_P0_ANALOG_MASK
		& ~gpp_ain_to_pins(analog_input_disable_low_reg);
	// Comparator path ignores data and direction registers
	assign comparator_input_en_out = ~ctrl_reg[GPP_CTRL_CMP_DIS_BIT];
	gpp_pin_ctrl #(
		.OPEN_DRAIN_MASK(GPP_P0_OPEN_DRAIN_MASK),
		.PULL_MASK(GPP_P0_PULL_MASK)
	) u_port0 (
		.latch_in(port0_data_latch_reg),
		.dir_in(port0_direction_reg),
		.pull_in(port0_pullup_enable_reg),
		.periph_oe_in(p0_periph_oe_in),
		.periph_out_in(p0_periph_out_in),
		.digital_en_in(p0_dig_en),
		.wake_en_in(p0_irq_enable_in),
		.standby_hold_in(hold),
		.pin_in(p0_pin_in),
		.pin_out(p0_pin_out),
		.pin_oe_out(p0_pin_oe_out),
		.pullup_out(p0_pullup_out),
		.pin_level_out(p0_level),
		.irq_level_out(p0_irq_level_out)
	);
	gpp_pin_ctrl #(
		.OPEN_DRAIN_MASK(GPP_P1_OPEN_DRAIN_MASK),
		.PULL_MASK(GPP_P1_PULL_MASK)
	) u_port1 (
		.latch_in(port1_data_latch_reg),
		.dir_in(port1_direction_reg),
		.pull_in(port1_pullup_enable_reg),
		.periph_oe_in(p1_periph_oe_in),
		.periph_out_in(p1_periph_out_in),
		.digital_en_in(8'hFF),
		.wake_en_in(p1_wake_enable_in),
		.standby_hold_in(hold),
		.pin_in(p1_pin_in),
		.pin_out(p1_pin_out),
		.pin_oe_out(p1_pin_oe_out),
		.pullup_out(p1_pullup_out),
		.pin_level_out(p1_level),
		.irq_level_out(p1_irq_level_out)
	);
	// Plain read: latch on port-driven outputs, pin level elsewhere
	function automatic logic [7:0] gpp_plain_read(input logic [7:0] latch,
		input logic [7:0] dir, input logic [7:0] poe, input logic [7:0] level);
		logic [7:0] port_out;
		port_out = dir & ~poe;
		gpp_plain_read = (port_out & latch) | (~port_out & level);
	endfunction
	// Read mux; the RMW alias addresses always return the latch
	always_comb begin
		rdata_next = 32'h0000_0000;
		case (rd_addr)
			GPP_ADDR_P0_DATA: rdata_next[7:0] = gpp_plain_read(port0_data_latch_reg,
				port0_direction_reg, p0_periph_oe_in, p0_level);
			GPP_ADDR_P1_DATA: rdata_next[7:0] = gpp_plain_read(port1_data_latch_reg,
				port1_direction_reg, p1_periph_oe_in, p1_level);
			GPP_ADDR_P0_RMW: rdata_next[7:0] = port0_data_latch_reg;
			GPP_ADDR_P1_RMW: rdata_next[7:0] = port1_data_latch_reg;
			GPP_ADDR_P0_DIR: rdata_next[7:0] = port0_direction_reg;
			GPP_ADDR_P1_DIR: rdata_next[7:0] = port1_direction_reg;
			GPP_ADDR_P0_PULL: rdata_next[7:0] = port0_pullup_enable_reg;
			GPP_ADDR_P1_PULL: rdata_next[7:0] = port1_pullup_enable_reg;
			GPP_ADDR_AIN_DIS: rdata_next[7:0] = analog_input_disable_low_reg;
			GPP_ADDR_CTRL: rdata_next[7:0] = ctrl_reg;
			default: rdata_next = 32'h0000_0000;
		endcase
	end
	// Read data captured at the address phase edge, held until the next read
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd_en) begin
			rdata_reg <= rdata_next;
		end
	end
	assign hrdata_out = rdata_reg;
	// Checks
	a_dir_reset: assert property (@(posedge clk_sys_in) !rst_n_in |=>
		port0_direction_reg == 8'h00 && port1_direction_reg == 8'h00)
		else $error("direction not cleared by reset");
	a_ain_reset: assert property (@(posedge clk_sys_in) !rst_n_in |=>
		p0_analog_en_out == GPP_P0_ANALOG_MASK)
		else $error("analog disable not cleared by reset");
	a_latch_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		wr_en && wr_addr == GPP_ADDR_P1_DATA |=> port1_data_latch_reg == $past(hwdata_in[7:0]))
		else $error("data write not stored in latch");
	a_hold_float: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		hold |-> p0_pin_oe_out == 8'h00 && p1_pin_oe_out == 8'h00)
		else $error("pins driven during standby hold");
	a_hold_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		hold |-> (p1_irq_level_out & ~p1_wake_enable_in) == 8'h00)
		else $error("blocked input not held low");
	a_no_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!ctrl_reg[GPP_CTRL_PIN_HOLD_BIT] |-> p1_pin_oe_out == (port1_direction_reg | p1_periph_oe_in))
		else $error("drive changed without hold select");
	a_out_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!hold && p1_periph_oe_in == 8'h00 |-> p1_pin_out == port1_data_latch_reg)
		else $error("output pin not driving latch");
	a_pull_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(p0_pullup_out & p0_pin_oe_out & ~p0_pin_out) == 8'h00)
		else $error("pull-up on while pin drives low");
	a_pull_bit0: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		p1_pullup_out[0] == 1'b0)
		else $error("pull-up on pin without one");
	a_rmw_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_en && rd_addr == GPP_ADDR_P0_RMW |=> hrdata_out[7:0] == $past(port0_data_latch_reg))
		else $error("RMW read not returning latch");
	a_cmp_en: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		comparator_input_en_out == !ctrl_reg[GPP_CTRL_CMP_DIS_BIT])
		else $error("comparator path wrong");
	// Drive, read path and standby checks; reads are judged one cycle after the decode
	a_dir_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!hold && p0_periph_oe_in == 8'h00 |-> p0_pin_oe_out == port0_direction_reg)
		else $error("pin direction not following direction bits");
	a_p0_latch_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		wr_en && wr_addr == GPP_ADDR_P0_DATA |=> port0_data_latch_reg == $past(hwdata_in[7:0]))
		else $error("port 0 data write not stored in latch");
	a_input_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_en && rd_addr == GPP_ADDR_P1_DATA && !hold |=> ((hrdata_out[7:0] ^ $past(p1_pin_in))
		& ~($past(port1_direction_reg) & ~$past(p1_periph_oe_in))) == 8'h00)
		else $error("plain read not returning pin level");
	a_port_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_en && rd_addr == GPP_ADDR_P1_DATA && p1_periph_oe_in == 8'h00 |=>
		((hrdata_out[7:0] ^ $past(port1_data_latch_reg)) & $past(port1_direction_reg)) == 8'h00)
		else $error("output pin read not returning latch");
	a_periph_drive: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!hold |-> (p1_pin_oe_out & p1_periph_oe_in) == p1_periph_oe_in
		&& ((p1_pin_out ^ p1_periph_out_in) & p1_periph_oe_in) == 8'h00)
		else $error("peripheral output not on its pin");
	a_hold_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		hold && rd_en && rd_addr == GPP_ADDR_P0_DATA |=> (hrdata_out[7:0]
		& ~$past(port0_direction_reg) & ~$past(p0_irq_enable_in)) == 8'h00)
		else $error("blocked input not reading low");
	a_p0_wake_open: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		hold |-> (p0_irq_level_out & ~p0_irq_enable_in) == 8'h00
		&& (p0_irq_level_out & p0_irq_enable_in) == (p0_pin_in & p0_irq_enable_in))
		else $error("port 0 wake input wrong in standby");
	a_p1_pull_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(p1_pullup_out & p1_pin_oe_out & ~p1_pin_out) == 8'h00)
		else $error("port 1 pull-up on while pin drives low");
	a_irq_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		!hold |-> p0_irq_level_out == p0_pin_in && p1_irq_level_out == p1_pin_in)
		else $error("pin level not reaching interrupt circuit");
	a_ain_block: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(p0_analog_en_out & p0_level) == 8'h00)
		else $error("digital input open on analog pin");
	c_rmw_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_en && rd_addr == GPP_ADDR_P1_RMW);
	c_hold_entry: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(hold));
	c_out_port: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		port1_direction_reg != 8'h00 && !hold);
	c_plain_read: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		rd_en && rd_addr == GPP_ADDR_P0_DATA);
	c_periph_drive: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		p0_periph_oe_in != 8'h00);
endmodule // gpp_port_top

// [verification/gpp_board_model.sv]
// Board side model of one 8-pin port: resolves each pin from all drivers
module gpp_board_model (
	input wire logic clk_sys_in,
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] pull_in,
	input wire logic [7:0] ext_en_in,
	input wire logic [7:0] ext_val_in,
	output logic [7:0] level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_reg;
	// Device drive wins, then the board, then the pull-up; a floating pin
	// shows the inverse of its last level so a stale value never passes
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (oe_in[i]) begin
				level_out[i] = drv_in[i];
			end else if (ext_en_in[i]) begin
				level_out[i] = ext_val_in[i];
			end else if (pull_in[i]) begin
				level_out[i] = 1'b1;
			end else begin
				level_out[i] = ~last_reg[i];
			end
		end
	end
	// Remember the level for the floating case
	always_ff @(posedge clk_sys_in) begin
		last_reg <= level_out;
	end
endmodule // gpp_board_model

// [verification/tb_top.sv]
// Self-checking bench: AHB register access and pin behaviour of the port block
module tb_top import gpp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, standby = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = GPP_HSIZE_WORD;
	logic hready, hresp;
	logic [7:0] p0_poe = 8'h00, p0_pout = 8'h00, p1_poe = 8'h00, p1_pout = 8'h00;
	logic [7:0] p0_irq_en = 8'h00, p1_wake_en = 8'h00, p0_ext = 8'h3C, p1_ext = 8'h96;
	logic [7:0] p0_lvl, p1_lvl, p0_out, p0_oe, p0_pu, p1_out, p1_oe, p1_pu;
	logic [7:0] p0_irq, p1_irq, p0_an;
	logic comp_en;
	int fails = 0, n_checks = 0;
	logic [31:0] rd;
	// 200 MHz system clock
	always #2.5 clk_sys_in = ~clk_sys_in;
	gpp_port_top DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
		.hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(hresp), .standby_entry_in(standby), .p0_periph_oe_in(p0_poe),
		.p0_periph_out_in(p0_pout), .p1_periph_oe_in(p1_poe), .p1_periph_out_in(p1_pout),
		.p0_irq_enable_in(p0_irq_en), .p1_wake_enable_in(p1_wake_en), .p0_pin_in(p0_lvl),
		.p1_pin_in(p1_lvl), .p0_pin_out(p0_out), .p0_pin_oe_out(p0_oe),
		.p0_pullup_out(p0_pu), .p1_pin_out(p1_out), .p1_pin_oe_out(p1_oe),
		.p1_pullup_out(p1_pu), .p0_irq_level_out(p0_irq), .p1_irq_level_out(p1_irq),
		.p0_analog_en_out(p0_an), .comparator_input_en_out(comp_en));
	// Board drives every pin that the device leaves free
	gpp_board_model board0 (.clk_sys_in(clk_sys_in), .drv_in(p0_out), .oe_in(p0_oe),
		.pull_in(p0_pu), .ext_en_in(8'hFF), .ext_val_in(p0_ext), .level_out(p0_lvl));
	gpp_board_model board1 (.clk_sys_in(clk_sys_in), .drv_in(p1_out), .oe_in(p1_oe),
		.pull_in(p1_pu), .ext_en_in(8'hFF), .ext_val_in(p1_ext), .level_out(p1_lvl));
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Bounded wait for hready at a rising edge; the bus never assumes a latency
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			fails++;
			close_out();
		end
	endtask
	task automatic ahb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= GPP_HTRANS_NONSEQ;
		haddr <= {24'h0, addr};
		hwrite <= wr;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask
	task automatic wr8(input logic [7:0] addr, input logic [7:0] d);
		ahb_xfer(1'b1, addr, {24'h0, d});
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] addr, input logic [31:0] exp);
		ahb_xfer(1'b0, addr, 32'h0);
		n_checks++;
		if (rd !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, rd);
		end
		if (hresp !== 1'b0) begin
			fails++;
			$display("wrong value hresp expected 0 seen %b", hresp);
		end
	endtask
	// Pins are combinational; let one edge pass so everything has settled
	task automatic chk_pin(input string nm, input logic [7:0] exp, ref logic [7:0] got);
		@(posedge clk_sys_in);
		#1;
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic do_reset();
		rst_n_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
	endtask
	// Watchdog on the whole run
	initial begin
		#200000;
		fails++;
		close_out();
	end
	initial begin
		logic [7:0] zero_regs [5];
		logic [7:0] cv;
		zero_regs = '{GPP_ADDR_P0_DIR, GPP_ADDR_P1_DIR, GPP_ADDR_P0_PULL,
			GPP_ADDR_AIN_DIS, GPP_ADDR_CTRL};
		do_reset();
		for (int i = 0; i < 5; i++) chk_reg("reset reg", zero_regs[i], 32'h0);
		chk_pin("p0 oe", 8'h00, p0_oe);
		chk_pin("p0 analog", GPP_P0_ANALOG_MASK, p0_an);
		cv = {7'h0, comp_en};
		chk_pin("comparator en", 8'h01, cv);
		wr8(GPP_ADDR_P0_DATA, 8'hA5);
		wr8(GPP_ADDR_P1_DATA, 8'h5A);
		chk_pin("p0 oe input", 8'h00, p0_oe);
		chk_reg("p0 rmw", GPP_ADDR_P0_RMW, 32'hA5);
		chk_reg("p0 analog read", GPP_ADDR_P0_DATA, 32'h0C);
		wr8(GPP_ADDR_AIN_DIS, 8'h33);
		chk_pin("p0 analog off", 8'h00, p0_an);
		chk_reg("p0 pin read", GPP_ADDR_P0_DATA, 32'h3C);
		chk_reg("p1 pin read", GPP_ADDR_P1_DATA, 32'h96);
		wr8(GPP_ADDR_P0_DIR, 8'h0F);
		chk_pin("p0 oe mixed", 8'h0F, p0_oe);
		cv = p0_out & 8'h0F;
		chk_pin("p0 drive", 8'h05, cv);
		chk_reg("p0 mixed read", GPP_ADDR_P0_DATA, 32'h35);
		chk_pin("p0 irq level", 8'h35, p0_irq);
		wr8(GPP_ADDR_P1_DIR, 8'hFF);
		p1_poe <= 8'hF0;
		p1_pout <= 8'hC3;
		chk_pin("p1 drive periph", 8'hCA, p1_out);
		chk_reg("p1 periph read", GPP_ADDR_P1_DATA, 32'hCA);
		chk_reg("p1 periph rmw", GPP_ADDR_P1_RMW, 32'h5A);
		chk_reg("p1 out read", GPP_ADDR_P1_DATA, 32'hCA);
		p1_poe <= 8'h00;
		chk_reg("p1 port read", GPP_ADDR_P1_DATA, 32'h5A);
		wr8(GPP_ADDR_P0_PULL, 8'hFF);
		chk_pin("p0 pullup", 8'hF5, p0_pu);
		wr8(GPP_ADDR_P1_PULL, 8'hFF);
		wr8(GPP_ADDR_P1_DIR, 8'h00);
		chk_pin("p1 pullup", GPP_P1_PULL_MASK, p1_pu);
		chk_reg("p1 pull reg", GPP_ADDR_P1_PULL, 32'hFF);
		wr8(GPP_ADDR_P0_PULL, 8'h00);
		// Standby with pins held: everything floats, only enabled wake inputs pass
		wr8(GPP_ADDR_CTRL, 8'h01);
		p0_irq_en <= 8'h10;
		p1_wake_en <= 8'h80;
		standby <= 1'b1;
		chk_pin("p0 oe hold", 8'h00, p0_oe);
		chk_pin("p0 irq hold", 8'h10, p0_irq);
		chk_pin("p1 irq hold", 8'h80, p1_irq);
		chk_reg("p0 hold read", GPP_ADDR_P0_DATA, 32'h15);
		wr8(GPP_ADDR_CTRL, 8'h00);
		chk_pin("p0 oe kept", 8'h0F, p0_oe);
		cv = p0_out & 8'h0F;
		chk_pin("p0 drive kept", 8'h05, cv);
		standby <= 1'b0;
		wr8(GPP_ADDR_CTRL, 8'h02);
		chk_reg("ctrl read", GPP_ADDR_CTRL, 32'h02);
		cv = {7'h0, comp_en};
		chk_pin("comparator off", 8'h00, cv);
		wr8(8'h40, 8'hFF);
		chk_reg("unmapped", 8'h40, 32'h0);
		do_reset();
		chk_reg("dir after reset", GPP_ADDR_P0_DIR, 32'h0);
		chk_pin("p0 oe after reset", 8'h00, p0_oe);
		close_out();
	end
endmodule // tb_top
